// file: inc/sbch_pkg.sv
package sbch_pkg;
    // Phase codes presented on the shared bus (msg, cd, io)
    localparam logic [2:0] PH_DATA_OUT = 3'h0;
    localparam logic [2:0] PH_DATA_IN = 3'h1;
    localparam logic [2:0] PH_COMMAND = 3'h2;
    localparam logic [2:0] PH_STATUS = 3'h3;
    localparam logic [2:0] PH_MSG_OUT = 3'h6;
    localparam logic [2:0] PH_MSG_IN = 3'h7;
    // Bit positions inside the phase code
    localparam int PH_IO_BIT = 0;
    localparam int PH_CD_BIT = 1;
    localparam int PH_MSG_BIT = 2;
    // Timing, in ns, and derived cycle counts at 10 MHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int DESKEW_NS = 45;
    localparam int BUS_CLEAR_NS = 800;
    localparam int RESET_HOLD_NS = 25000;
    localparam int GLITCH_NS = 400;
    // Least times round up
    localparam int DESKEW_CYC = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest times round down, at least one cycle
    localparam int BUS_CLEAR_CYC = (BUS_CLEAR_NS / CLK_PERIOD_NS) < 1 ? 1 : BUS_CLEAR_NS / CLK_PERIOD_NS;
    localparam int GLITCH_RAW = (GLITCH_NS / CLK_PERIOD_NS) < 1 ? 1 : GLITCH_NS / CLK_PERIOD_NS;
    // Confirmation plus two synchroniser stages stays inside the bus clear delay
    localparam int GLITCH_CYC = (GLITCH_RAW + 2 > BUS_CLEAR_CYC) ? BUS_CLEAR_CYC - 2 : GLITCH_RAW;
    localparam int ATN_LEAD_CYC = 2 * DESKEW_CYC;
    localparam int CNT_W = 16;
    localparam int PTR_W = 32;
    localparam int TAG_W = 2;
    localparam int NUM_TASKS = 4;
    // Bus width / transfer mode after a transceiver mode change
    localparam logic WIDTH_8BIT = 1'b0;
    localparam logic MODE_ASYNC = 1'b0;
    // Sense codes for unit attention on mode change (arbitrary encodings)
    localparam logic [1:0] UA_NONE = 2'h0;
    localparam logic [1:0] UA_TO_SE = 2'h1;
    localparam logic [1:0] UA_TO_LVD = 2'h2;

    typedef enum logic [2:0] {
        SBCH_BUS_FREE,
        SBCH_ARB,
        SBCH_SEL,
        SBCH_RESEL,
        SBCH_INFO
    } sbch_bus_t;
endpackage

// file: inc/sbch_if.sv
`timescale 1ns/100ps
interface sbch_if;
    // Target-driven lines
    logic bsy_t_o, bsy_t_oe, req_o, req_oe;
    logic [2:0] phase_o;
    logic phase_oe;
    // Initiator-driven lines
    logic atn_o, atn_oe, ack_o, ack_oe, sel_o, sel_oe, bsy_i_o, bsy_i_oe;
    // Either end may drive reset
    logic rst_t_oe, rst_i_oe;
    // Resolved wire levels (true = asserted)
    logic bsy, req, ack, atn, sel, rst;
    logic [2:0] phase;
    assign bsy = (bsy_t_oe & bsy_t_o) | (bsy_i_oe & bsy_i_o);
    assign req = req_oe & req_o;
    assign ack = ack_oe & ack_o;
    assign atn = atn_oe & atn_o;
    assign sel = sel_oe & sel_o;
    assign rst = rst_t_oe | rst_i_oe;
    assign phase = phase_oe ? phase_o : 3'h0;

    modport tgt (output bsy_t_o, bsy_t_oe, req_o, req_oe, phase_o, phase_oe, rst_t_oe,
                 input bsy, ack, atn, sel, rst);
    modport ini (output atn_o, atn_oe, ack_o, ack_oe, sel_o, sel_oe, bsy_i_o, bsy_i_oe, rst_i_oe,
                 input bsy, req, phase, rst);
endinterface

// file: rtl/sbch_target.sv
`timescale 1ns/100ps
module sbch_target (
    input wire logic mclk,
    input wire logic rst,
    sbch_if.tgt bus,
    input wire logic reselect,
    input wire logic [2:0] next_phase,
    input wire logic xfer_req,
    input wire logic last_byte,
    input wire logic final_msg,
    input wire logic end_nexus,
    input wire logic xcvr_lvd,
    input wire logic drive_rst,
    output logic xfer_done,
    output logic bus_reset,
    output logic [1:0] ua_code,
    output logic width_wide,
    output logic mode_sync,
    output logic [2:0] cur_phase,
    output logic busy
);
    localparam int CW = sbch_pkg::CNT_W;
    typedef enum {
        SBCH_T_IDLE,
        SBCH_T_ID,
        SBCH_T_PH,
        SBCH_T_REQ,
        SBCH_T_ACK
    } sbch_tstate_t;

    logic [1:0] atn_s_q, ack_s_q, sel_s_q, rst_s_q, lvd_s_q;
    sbch_tstate_t st_q;
    logic [2:0] ph_q;
    logic atn_pend_q, lvd_q, hold_q, in_msgo_q, need_free_q;
    logic [1:0] warm_q;
    logic [CW-1:0] glitch_q, atn_low_q, hold_cnt_q;
    logic rst_conf, mode_chg;

    // Two-stage synchronisers; only stage 2 is read by logic
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            atn_s_q <= 2'h0;
            ack_s_q <= 2'h0;
            sel_s_q <= 2'h0;
            rst_s_q <= 2'h0;
            lvd_s_q <= 2'h0;
        end else begin
            atn_s_q <= {atn_s_q[0], bus.atn};
            ack_s_q <= {ack_s_q[0], bus.ack};
            sel_s_q <= {sel_s_q[0], bus.sel};
            rst_s_q <= {rst_s_q[0], bus.rst};
            lvd_s_q <= {lvd_s_q[0], xcvr_lvd};
        end
    end

    // Bus RST confirmed after a short filter, well inside the bus clear delay
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            glitch_q <= '0;
        end else if (!rst_s_q[1]) begin
            glitch_q <= '0;
        end else if (glitch_q < CW'(sbch_pkg::GLITCH_CYC)) begin
            glitch_q <= glitch_q + 1'b1;
        end
    end
    assign rst_conf = glitch_q >= CW'(sbch_pkg::GLITCH_CYC);

    // Transceiver mode tracking; first sample after release is taken as the start mode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lvd_q <= 1'b0;
            hold_q <= 1'b0;
            warm_q <= 2'h0;
        end else begin
            // Arm only once the synchroniser holds a real sample, so reset gives no false change
            lvd_q <= lvd_s_q[1];
            warm_q <= {warm_q[0], 1'b1};
            hold_q <= warm_q[1];
        end
    end
    assign mode_chg = hold_q && (lvd_q != lvd_s_q[1]);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ua_code <= sbch_pkg::UA_NONE;
            width_wide <= sbch_pkg::WIDTH_8BIT;
            mode_sync <= sbch_pkg::MODE_ASYNC;
            bus_reset <= 1'b0;
        end else begin
            bus_reset <= rst_conf || mode_chg;
            if (mode_chg) begin
                ua_code <= lvd_s_q[1] ? sbch_pkg::UA_TO_LVD : sbch_pkg::UA_TO_SE;
                width_wide <= sbch_pkg::WIDTH_8BIT;
                mode_sync <= sbch_pkg::MODE_ASYNC;
            end
        end
    end

    // Local hard-reset request held for the reset hold time
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_cnt_q <= '0;
        end else if (drive_rst && hold_cnt_q == '0 && !rst_s_q[1]) begin
            hold_cnt_q <= CW'(sbch_pkg::RESET_HOLD_CYC);
        end else if (hold_cnt_q != '0) begin
            hold_cnt_q <= hold_cnt_q - 1'b1;
        end
    end

    // Cycles since ATN fell, to judge the lead before ACK
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            atn_low_q <= '0;
        end else if (atn_s_q[1]) begin
            atn_low_q <= '0;
        end else if (atn_low_q != '1) begin
            atn_low_q <= atn_low_q + 1'b1;
        end
    end

    // Attention latched; set wins over clear on entering message out
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            atn_pend_q <= 1'b0;
        end else if (rst_conf || mode_chg || st_q == SBCH_T_IDLE) begin
            atn_pend_q <= 1'b0;
        end else if (atn_s_q[1]) begin
            atn_pend_q <= 1'b1;
        end else if (in_msgo_q) begin
            // Message out services the pending attention
            atn_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= SBCH_T_IDLE;
            ph_q <= sbch_pkg::PH_DATA_OUT;
            in_msgo_q <= 1'b0;
            need_free_q <= 1'b0;
            xfer_done <= 1'b0;
        end else if (rst_conf || mode_chg) begin
            st_q <= SBCH_T_IDLE;
            xfer_done <= 1'b0;
            need_free_q <= 1'b0;
            in_msgo_q <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            case (st_q)
                SBCH_T_IDLE: begin
                    if (sel_s_q[1] && !reselect) begin
                        st_q <= SBCH_T_PH;
                        ph_q <= atn_s_q[1] ? sbch_pkg::PH_MSG_OUT : next_phase;
                    end else if (reselect) begin
                        st_q <= SBCH_T_ID;
                        ph_q <= sbch_pkg::PH_MSG_IN;
                    end
                end
                SBCH_T_ID: begin
                    st_q <= SBCH_T_REQ; // Identify byte is sent first
                end
                SBCH_T_PH: begin
                    in_msgo_q <= (ph_q == sbch_pkg::PH_MSG_OUT);
                    if (end_nexus || need_free_q) begin
                        st_q <= SBCH_T_IDLE;
                        need_free_q <= 1'b0;
                    end else if (xfer_req || ph_q == sbch_pkg::PH_MSG_OUT) begin
                        st_q <= SBCH_T_REQ;
                    end
                end
                SBCH_T_REQ: begin
                    if (ack_s_q[1]) begin
                        st_q <= SBCH_T_ACK;
                        if (in_msgo_q && final_msg && atn_low_q < CW'(sbch_pkg::ATN_LEAD_CYC)) begin
                            need_free_q <= 1'b1;
                        end
                    end
                end
                SBCH_T_ACK: begin
                    if (!ack_s_q[1]) begin
                        xfer_done <= 1'b1;
                        st_q <= SBCH_T_PH;
                        if (in_msgo_q) begin
                            // Keep handshaking while ATN stays true
                            ph_q <= atn_s_q[1] ? sbch_pkg::PH_MSG_OUT : next_phase;
                        end else if (atn_pend_q || atn_s_q[1]) begin
                            // Status, message-in, command, data and identify all switch once acked
                            ph_q <= sbch_pkg::PH_MSG_OUT;
                        end else if (last_byte) begin
                            ph_q <= next_phase;
                        end
                    end
                end
                default: st_q <= SBCH_T_IDLE;
            endcase
        end
    end

    // Bus outputs; BSY, REQ and phase released while RST is seen on the bus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus.bsy_t_o <= 1'b0;
            bus.bsy_t_oe <= 1'b0;
            bus.req_o <= 1'b0;
            bus.req_oe <= 1'b0;
            bus.phase_o <= 3'h0;
            bus.phase_oe <= 1'b0;
            bus.rst_t_oe <= 1'b0;
            cur_phase <= 3'h0;
            busy <= 1'b0;
        end else begin
            bus.rst_t_oe <= hold_cnt_q != '0;
            if (rst_s_q[1] || rst_conf || st_q == SBCH_T_IDLE) begin
                bus.bsy_t_o <= 1'b0;
                bus.bsy_t_oe <= 1'b0;
                bus.req_o <= 1'b0;
                bus.req_oe <= 1'b0;
                bus.phase_oe <= 1'b0;
                busy <= 1'b0;
            end else begin
                bus.bsy_t_o <= 1'b1;
                bus.bsy_t_oe <= 1'b1;
                bus.req_o <= st_q == SBCH_T_REQ;
                bus.req_oe <= 1'b1;
                bus.phase_o <= ph_q;
                bus.phase_oe <= 1'b1;
                busy <= 1'b1;
            end
            cur_phase <= ph_q;
        end
    end
endmodule // sbch_target

// file: rtl/sbch_initiator.sv
`timescale 1ns/100ps
module sbch_initiator (
    input wire logic mclk,
    input wire logic rst,
    sbch_if.ini bus,
    input wire logic start_sel,
    input wire logic want_atn,
    input wire logic msg_last,
    input wire logic drive_rst,
    input wire logic new_cmd,
    input wire logic save_dp,
    input wire logic restore_ptrs,
    input wire logic reconnect,
    input wire logic [sbch_pkg::TAG_W-1:0] task_tag,
    input wire logic [sbch_pkg::PTR_W-1:0] cmd_base,
    input wire logic [sbch_pkg::PTR_W-1:0] data_base,
    input wire logic [sbch_pkg::PTR_W-1:0] stat_base,
    output logic [sbch_pkg::PTR_W-1:0] act_cmd,
    output logic [sbch_pkg::PTR_W-1:0] act_data,
    output logic [sbch_pkg::PTR_W-1:0] act_stat,
    output logic byte_done,
    output logic connected
);
    localparam int PW = sbch_pkg::PTR_W;
    localparam int CW = sbch_pkg::CNT_W;
    logic [1:0] req_s_q, bsy_s_q, rst_s_q;
    logic [2:0] ph_s1_q, ph_s2_q;
    logic [PW-1:0] sv_data_q [sbch_pkg::NUM_TASKS];
    logic [PW-1:0] sv_cmd_q [sbch_pkg::NUM_TASKS];
    logic [PW-1:0] sv_stat_q [sbch_pkg::NUM_TASKS];
    logic [CW-1:0] hold_cnt_q, atn_lead_q;
    logic in_msgo;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_s_q <= 2'h0;
            bsy_s_q <= 2'h0;
            rst_s_q <= 2'h0;
            ph_s1_q <= 3'h0;
            ph_s2_q <= 3'h0;
        end else begin
            req_s_q <= {req_s_q[0], bus.req};
            bsy_s_q <= {bsy_s_q[0], bus.bsy};
            rst_s_q <= {rst_s_q[0], bus.rst};
            ph_s1_q <= bus.phase;
            ph_s2_q <= ph_s1_q;
        end
    end
    assign in_msgo = ph_s2_q == sbch_pkg::PH_MSG_OUT;

    // Saved and active pointers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_cmd <= '0;
            act_data <= '0;
            act_stat <= '0;
            for (int i = 0; i < sbch_pkg::NUM_TASKS; i++) begin
                sv_data_q[i] <= '0;
                sv_cmd_q[i] <= '0;
                sv_stat_q[i] <= '0;
            end
        end else if (new_cmd) begin
            sv_cmd_q[task_tag] <= cmd_base; // Saved command/status stay at area starts
            sv_stat_q[task_tag] <= stat_base;
            sv_data_q[task_tag] <= data_base;
            act_cmd <= cmd_base;
            act_data <= data_base;
            act_stat <= stat_base;
        end else if (save_dp) begin
            sv_data_q[task_tag] <= act_data;
        end else if (restore_ptrs || reconnect) begin
            act_cmd <= sv_cmd_q[task_tag];
            act_data <= sv_data_q[task_tag];
            act_stat <= sv_stat_q[task_tag];
        end else if (byte_done && ph_s2_q[sbch_pkg::PH_CD_BIT] == 1'b0) begin
            act_data <= act_data + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_cnt_q <= '0;
        end else if (drive_rst && hold_cnt_q == '0) begin
            hold_cnt_q <= CW'(sbch_pkg::RESET_HOLD_CYC);
        end else if (hold_cnt_q != '0) begin
            hold_cnt_q <= hold_cnt_q - 1'b1;
        end
    end

    // Counts how long ATN has stood low before the final ACK
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            atn_lead_q <= '0;
        end else if (bus.atn_o) begin
            atn_lead_q <= '0;
        end else if (atn_lead_q != '1) begin
            atn_lead_q <= atn_lead_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus.atn_o <= 1'b0;
            bus.atn_oe <= 1'b0;
            bus.ack_o <= 1'b0;
            bus.ack_oe <= 1'b0;
            bus.sel_o <= 1'b0;
            bus.sel_oe <= 1'b0;
            bus.bsy_i_o <= 1'b0;
            bus.bsy_i_oe <= 1'b0;
            bus.rst_i_oe <= 1'b0;
            byte_done <= 1'b0;
            connected <= 1'b0;
        end else begin
            bus.rst_i_oe <= hold_cnt_q != '0;
            byte_done <= 1'b0;
            if (rst_s_q[1]) begin
                bus.atn_o <= 1'b0;
                bus.atn_oe <= 1'b0;
                bus.ack_o <= 1'b0;
                bus.ack_oe <= 1'b0;
                bus.sel_o <= 1'b0;
                bus.sel_oe <= 1'b0;
                bus.bsy_i_oe <= 1'b0;
                connected <= 1'b0;
            end else if (!connected) begin
                bus.sel_o <= start_sel;
                bus.sel_oe <= start_sel;
                bus.atn_o <= start_sel && want_atn;
                bus.atn_oe <= start_sel && want_atn;
                if (bus.sel_o && bsy_s_q[1]) begin
                    connected <= 1'b1;
                    bus.sel_o <= 1'b0;
                    bus.sel_oe <= 1'b0;
                end
            end else begin
                if (!bsy_s_q[1]) begin
                    connected <= 1'b0;
                    bus.atn_o <= 1'b0;
                    bus.atn_oe <= 1'b0;
                end else if (want_atn) begin
                    // Raising ATN during ACK lets it lead the ACK release
                    bus.atn_o <= 1'b1;
                    bus.atn_oe <= 1'b1;
                end else if (in_msgo && msg_last && req_s_q[1] && !bus.ack_o) begin
                    bus.atn_o <= 1'b0;
                    bus.atn_oe <= 1'b0;
                end
                // Final message byte waits for the ATN lead; other bytes handshake at once
                if (req_s_q[1] && !bus.ack_o &&
                    (!(in_msgo && msg_last) || atn_lead_q >= CW'(sbch_pkg::ATN_LEAD_CYC))) begin
                    bus.ack_o <= 1'b1;
                    bus.ack_oe <= 1'b1;
                end else if (!req_s_q[1] && bus.ack_o) begin
                    bus.ack_o <= 1'b0;
                    bus.ack_oe <= 1'b0;
                    byte_done <= 1'b1;
                end
            end
        end
    end
endmodule // sbch_initiator

// file: dv/sbch_monitor.sv
`timescale 1ns/100ps
module sbch_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic bsy,
    input wire logic req,
    input wire logic ack,
    input wire logic atn,
    input wire logic sel,
    input wire logic [2:0] phase,
    input wire logic rst_t_oe,
    input wire logic rst_i_oe,
    input wire logic bsy_t_oe,
    input wire logic req_oe,
    input wire logic phase_oe,
    input wire logic atn_oe,
    input wire logic ack_oe,
    input wire logic sel_oe,
    input wire logic bsy_i_oe
);
    logic [15:0] hold_t_q;
    logic [15:0] hold_i_q;
    logic line_rst;
    logic any_oe;
    assign line_rst = rst_t_oe | rst_i_oe;
    assign any_oe = bsy_t_oe | req_oe | phase_oe | atn_oe | ack_oe | sel_oe | bsy_i_oe;
    // Cycles each end has held the reset line so far
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_t_q <= 16'h0;
            hold_i_q <= 16'h0;
        end else begin
            hold_t_q <= rst_t_oe ? hold_t_q + 16'h1 : 16'h0;
            hold_i_q <= rst_i_oe ? hold_i_q + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_BUS_CLEAR: assert property ($rose(line_rst) |-> ##[0:8] !any_oe)
        else $error("bus not released after reset line rose");
    AST_HOLD_T: assert property ($fell(rst_t_oe) |-> hold_t_q >= 16'(sbch_pkg::RESET_HOLD_CYC))
        else $error("target reset pulse too short");
    AST_HOLD_I: assert property ($fell(rst_i_oe) |-> hold_i_q >= 16'(sbch_pkg::RESET_HOLD_CYC))
        else $error("initiator reset pulse too short");
    AST_FREE_AFTER: assert property ($fell(line_rst) |-> !bsy && !req)
        else $error("bus not free after reset");
    AST_SEL_ATN: assert property (disable iff (rst || line_rst)
        $rose(bsy_t_oe) && sel && atn |-> ##[0:6] (req && phase == sbch_pkg::PH_MSG_OUT))
        else $error("no message out after selection with attention");
    AST_ATN_ACK: assert property (disable iff (rst || line_rst)
        $fell(atn) |-> !($past(ack) && $past(phase) == sbch_pkg::PH_MSG_OUT))
        else $error("attention dropped during acknowledge");
    AST_ATN_PHASE: assert property (disable iff (rst || line_rst) $rose(atn) |-> sel || bsy)
        else $error("attention raised on a free bus");
    AST_ACK_FOLLOWS: assert property (disable iff (rst || line_rst) $rose(req) |-> ##[1:8] ack)
        else $error("request not acknowledged");
    AST_REQ_HOLD: assert property (disable iff (rst || line_rst) $fell(req) |-> $past(ack))
        else $error("request dropped before acknowledge");
    cover property ($rose(bsy_t_oe) && atn);
    cover property (req && ack && phase == sbch_pkg::PH_MSG_OUT);
    cover property ($rose(line_rst));
endmodule // sbch_monitor

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic xfer_req = 1'h0, last_byte = 1'h0, end_nexus = 1'h0, xcvr_lvd = 1'h1, start_sel = 1'h0;
    logic want_atn = 1'h0, msg_last = 1'h0, i_drst = 1'h0, new_cmd = 1'h0, save_dp = 1'h0;
    logic restore_ptrs = 1'h0, reconnect = 1'h0, t_drst = 1'h0;
    logic [2:0] next_phase = 3'h0;
    logic [1:0] task_tag = 2'h0;
    logic [sbch_pkg::PTR_W-1:0] cmd_base = 32'h0, data_base = 32'h0, stat_base = 32'h0;
    logic [sbch_pkg::PTR_W-1:0] act_cmd, act_data, act_stat, b1, b2;
    logic byte_done, bus_reset, busy, width_wide, mode_sync;
    logic [1:0] ua_code;
    logic [2:0] exp_q[$];
    logic [2:0] ph_tab[5] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h7};
    int err_total = 0;
    int n_tests = 0;
    integer seed = 32'hF8755A36;
    sbch_if bus();
    sbch_target sbch_target_i (.mclk(mclk), .rst(rst), .bus(bus.tgt), .reselect(1'h0), .next_phase(next_phase),
        .xfer_req(xfer_req), .last_byte(last_byte), .final_msg(msg_last), .end_nexus(end_nexus), .xcvr_lvd(xcvr_lvd),
        .drive_rst(t_drst), .xfer_done(), .bus_reset(bus_reset), .ua_code(ua_code), .width_wide(width_wide),
        .mode_sync(mode_sync), .cur_phase(), .busy(busy));
    sbch_initiator sbch_initiator_i (.mclk(mclk), .rst(rst), .bus(bus.ini), .start_sel(start_sel),
        .want_atn(want_atn), .msg_last(msg_last), .drive_rst(i_drst), .new_cmd(new_cmd), .save_dp(save_dp),
        .restore_ptrs(restore_ptrs), .reconnect(reconnect), .task_tag(task_tag), .cmd_base(cmd_base),
        .data_base(data_base), .stat_base(stat_base), .act_cmd(act_cmd), .act_data(act_data),
        .act_stat(act_stat), .byte_done(byte_done), .connected());
    sbch_monitor sbch_monitor_i (.mclk(mclk), .rst(rst), .bsy(bus.bsy), .req(bus.req), .ack(bus.ack),
        .atn(bus.atn), .sel(bus.sel), .phase(bus.phase), .rst_t_oe(bus.rst_t_oe), .rst_i_oe(bus.rst_i_oe),
        .bsy_t_oe(bus.bsy_t_oe), .req_oe(bus.req_oe), .phase_oe(bus.phase_oe), .atn_oe(bus.atn_oe),
        .ack_oe(bus.ack_oe), .sel_oe(bus.sel_oe), .bsy_i_oe(bus.bsy_i_oe));
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'h1) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Pulse one pointer command, then compare the active set
    task automatic ptr_op(input int op, input logic [1:0] tag, input logic [31:0] d);
        task_tag <= tag;
        new_cmd <= (op == 0);
        save_dp <= (op == 1);
        restore_ptrs <= (op == 2);
        reconnect <= (op == 3);
        cyc(1);
        {new_cmd, save_dp, restore_ptrs, reconnect} <= 4'h0;
        cyc(2);
        check(act_cmd === cmd_base && act_stat === stat_base && act_data === d, "pointers");
    endtask
    task automatic run_phase(input logic [2:0] ph, input logic atn2);
        exp_q.push_back(sbch_pkg::PH_MSG_OUT);
        exp_q.push_back(ph);
        exp_q.push_back(ph);
        if (atn2) exp_q.push_back(sbch_pkg::PH_MSG_OUT);
        {next_phase, last_byte, msg_last, want_atn, xfer_req, start_sel} <= {ph, 5'h1F};
        // Drop ATN once message out is requested; raise it again during the third acknowledge
        for (int k = 0; k < 400 && exp_q.size() > 0; k++) begin
            cyc(1);
            if (bus.req === 1'h1 && bus.phase === sbch_pkg::PH_MSG_OUT) want_atn <= 1'h0;
            else if (atn2 && exp_q.size() == 2 && bus.ack === 1'h1) want_atn <= 1'h1;
        end
        check(exp_q.size() == 0, "handshakes stalled");
        exp_q.delete();
        {xfer_req, start_sel, want_atn, end_nexus} <= 4'h1;
        cyc(10);
        check(busy === 1'h0 && bus.bsy === 1'h0, "no bus free at end");
        end_nexus <= 1'h0;
        cyc(4);
    endtask
    task automatic connect;
        {xfer_req, want_atn, start_sel} <= 3'h1;
        for (int k = 0; k < 30 && busy !== 1'h1; k++) cyc(1);
        start_sel <= 1'h0;
        cyc(2);
    endtask
    task automatic mode_chg(input logic lvd, input logic [1:0] ua);
        connect();
        xcvr_lvd <= lvd;
        for (int k = 0; k < 30 && ua_code !== ua; k++) cyc(1);
        cyc(10);
        check(ua_code === ua && bus.rst === 1'h0, "mode change event");
        check(width_wide === sbch_pkg::WIDTH_8BIT && mode_sync === sbch_pkg::MODE_ASYNC, "width");
        check(busy === 1'h0 && bus.bsy === 1'h0, "mode change bus free");
    endtask
    initial forever #50 mclk = ~mclk;
    always @(negedge mclk) begin
        if (byte_done === 1'h1 && exp_q.size() > 0) check(bus.phase === exp_q.pop_front(), "phase");
    end
    initial begin
        cyc(20000);
        err_total++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        cyc(1);
        foreach (ph_tab[i]) for (int a = 0; a < 2; a++) run_phase(ph_tab[i], a[0]);
        b1 = $random(seed);
        b2 = $random(seed);
        {cmd_base, data_base, stat_base} <= {b1, b2, b1 ^ b2};
        ptr_op(0, 2'h1, b2);
        {cmd_base, data_base, stat_base} <= {b2, b1, ~b1};
        ptr_op(0, 2'h2, b1);
        // Save the other task's active data pointer into task 1
        ptr_op(1, 2'h1, b1);
        {cmd_base, data_base, stat_base} <= {b1, b2, b1 ^ b2};
        ptr_op(3, 2'h1, b1);
        ptr_op(2, 2'h1, b1);
        // Initiator, then target, creates a hard reset
        for (int w = 0; w < 2; w++) begin
            connect();
            {t_drst, i_drst} <= w[0] ? 2'h2 : 2'h1;
            cyc(1);
            {t_drst, i_drst} <= 2'h0;
            for (int k = 0; k < 20 && bus_reset !== 1'h1; k++) cyc(1);
            check(bus_reset === 1'h1 && bus.rst_t_oe === w[0], "reset not taken");
            for (int k = 0; k < 400 && bus.rst !== 1'h0; k++) cyc(1);
            cyc(6);
            check(bus.rst === 1'h0 && busy === 1'h0 && bus.bsy === 1'h0, "no bus free after reset");
        end
        mode_chg(1'h0, sbch_pkg::UA_TO_SE);
        mode_chg(1'h1, sbch_pkg::UA_TO_LVD);
        test_done();
    end
endmodule // tb
